// ---- ipr_field.sv ----
/*
  One 3-bit priority field with its own storage.
  Assumes the parent decodes address and byte lane into wr_en.
*/
`timescale 1ns/1ps
`default_nettype none
module ipr_field
  import ipr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [ipr_pkg::LVL_W-1:0] wr_level,
  // Stored level
  output logic [ipr_pkg::LVL_W-1:0] level
);

  typedef struct packed {
    logic [LVL_W-1:0] level;
  } ipr_field_st_t;

  ipr_field_st_t st_r;
  ipr_field_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (wr_en)
    begin
      st_nxt.level = wr_level;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r.level <= LVL_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.level;

endmodule : ipr_field
`default_nettype wire

// ---- ipr_pkg.sv ----
/*
  Constants for the upper interrupt priority register bank: register offsets,
  field placement, reset level and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
`default_nettype none
package ipr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_SRC = 16;
  localparam int LVL_W = 3;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Priority codes: the code is the level itself
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h4;
  localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [5:0] OFF_CLOCK_CALENDAR = 6'h00;
  localparam logic [5:0] OFF_CHECKSUM_SERIAL_ERR = 6'h04;
  localparam logic [5:0] OFF_LOW_VOLTAGE = 6'h08;
  localparam logic [5:0] OFF_CHARGE_TIME = 6'h0C;
  localparam logic [5:0] OFF_SERIAL3 = 6'h10;
  localparam logic [5:0] OFF_SERIAL4_ERR_TWOWIRE3 = 6'h14;
  localparam logic [5:0] OFF_SYNC3_SERIAL4 = 6'h18;
  localparam logic [5:0] OFF_ENABLE_STATUS = 6'h1C;

  // Word index of each register (offset / 4)
  localparam logic [2:0] IDX_CLOCK_CALENDAR = OFF_CLOCK_CALENDAR[4:2];
  localparam logic [2:0] IDX_CHECKSUM_SERIAL_ERR = OFF_CHECKSUM_SERIAL_ERR[4:2];
  localparam logic [2:0] IDX_LOW_VOLTAGE = OFF_LOW_VOLTAGE[4:2];
  localparam logic [2:0] IDX_CHARGE_TIME = OFF_CHARGE_TIME[4:2];
  localparam logic [2:0] IDX_SERIAL3 = OFF_SERIAL3[4:2];
  localparam logic [2:0] IDX_SERIAL4_ERR_TWOWIRE3 = OFF_SERIAL4_ERR_TWOWIRE3[4:2];
  localparam logic [2:0] IDX_SYNC3_SERIAL4 = OFF_SYNC3_SERIAL4[4:2];
  localparam logic [2:0] IDX_ENABLE_STATUS = OFF_ENABLE_STATUS[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // Field placement, source order:
  // 0 calendar, 1 checksum err, 2 serial2 err, 3 serial1 err, 4 low voltage,
  // 5 charge time, 6 serial3 tx, 7 serial3 rx, 8 serial3 err, 9 serial4 err,
  // 10 twowire3 master, 11 twowire3 slave, 12 sync3 event, 13 sync3 fault,
  // 14 serial4 tx, 15 serial4 rx
  localparam logic [2:0] FIELD_REG [NUM_SRC] = '{
    IDX_CLOCK_CALENDAR,
    IDX_CHECKSUM_SERIAL_ERR, IDX_CHECKSUM_SERIAL_ERR, IDX_CHECKSUM_SERIAL_ERR,
    IDX_LOW_VOLTAGE,
    IDX_CHARGE_TIME,
    IDX_SERIAL3, IDX_SERIAL3, IDX_SERIAL3,
    IDX_SERIAL4_ERR_TWOWIRE3, IDX_SERIAL4_ERR_TWOWIRE3, IDX_SERIAL4_ERR_TWOWIRE3,
    IDX_SYNC3_SERIAL4, IDX_SYNC3_SERIAL4, IDX_SYNC3_SERIAL4, IDX_SYNC3_SERIAL4
  };
  localparam int FIELD_LSB [NUM_SRC] = '{
    8,
    12, 8, 4,
    0,
    4,
    12, 8, 4,
    12, 4, 0,
    12, 8, 4, 0
  };
  // Byte lane that carries bit 8 and above
  localparam int HIGH_LANE_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ipr_pkg
`default_nettype wire

// ---- ipr_regs.sv ----
/*
  Upper interrupt priority register bank behind an AXI4-Lite slave.
  Holds sixteen 3-bit priority fields, presents each as a level to the
  arbitration logic and gates each source request when its level is zero.
  Assumes one clock, a synchronous active-low reset and a master that keeps
  at most one write and one read outstanding.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Code 111 gives the source level 7, the highest user level.
// - Code 001 gives level 1; every code maps to its own binary value.
// - Code 000 disables the source; it never raises a request.
// - Bits outside priority fields ignore writes and read as zero, except the status word, which reads one enable bit per source.
// - Reset loads every priority field with level 4.
// - Every field bit is readable and writable, returning the last write.
// - Calendar register: calendar level at bits 10-8 only.
// - Checksum/serial error register: fields at 14-12, 10-8 and 6-4.
// - Low-voltage register: level at bits 2-0; bits 15-3 unused.
// - Charge-time register: level at bits 6-4 only.
// - Serial3 register: transmit 14-12, receive 10-8, error 6-4.
// - Serial4 error 14-12, two-wire master 6-4, slave 2-0.
// - Sync3 event 14-12, fault 10-8; serial4 transmit 6-4, receive 2-0.
module ipr_regs
  import ipr_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ADDR_W-1:0] s_awaddr,
  // AXI4-Lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [ipr_pkg::DATA_W-1:0] s_wdata,
  input wire logic [ipr_pkg::STRB_W-1:0] s_wstrb,
  // AXI4-Lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ADDR_W-1:0] s_araddr,
  // AXI4-Lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [ipr_pkg::DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  // Pending flags from the sources, already enabled
  input wire logic [ipr_pkg::NUM_SRC-1:0] src_pending,
  // Requests to the arbiter, gated by a non-zero level
  output logic [ipr_pkg::NUM_SRC-1:0] source_request,
  // Source levels to the arbiter
  output logic [ipr_pkg::LVL_W-1:0] calendar_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] checksum_err_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial2_err_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial1_err_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] low_voltage_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] charge_time_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial3_tx_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial3_rx_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial3_err_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial4_err_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] twowire3_master_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] twowire3_slave_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] sync3_event_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] sync3_fault_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial4_tx_irq_level,
  output logic [ipr_pkg::LVL_W-1:0] serial4_rx_irq_level
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [REG_W-1:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [NUM_SRC-1:0] request;
  } ipr_regs_st_t;

  ipr_regs_st_t st_r;
  ipr_regs_st_t st_nxt;

  logic [NUM_SRC*LVL_W-1:0] lvl_flat;
  logic [NUM_SRC-1:0] field_wr;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr_now;
  logic [REG_W-1:0] wr_data_now;
  logic [1:0] wr_strb_now;
  logic [3:0] wr_dec;
  logic aw_take;
  logic w_take;
  logic [1:0] wr_resp;
  logic ar_take;
  logic [3:0] rd_dec;
  logic [REG_W-1:0] rd_word;
  logic [1:0] rd_resp;
  logic [NUM_SRC-1:0] src_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the write and read paths

  // Returns {mapped, word index}; the address is taken as a byte address
  function automatic logic [3:0] ipr_decode(input logic [ADDR_W-1:0] addr);
    logic mapped;
    mapped = (addr[ADDR_W-1:5] == '0);
    ipr_decode = {mapped, addr[4:2]};
  endfunction : ipr_decode

  // Writes to the status word are refused so software sees its mistake
  function automatic logic ipr_writable(input logic [3:0] dec);
    ipr_writable = dec[3] && (dec[2:0] != IDX_ENABLE_STATUS);
  endfunction : ipr_writable

  // Picks one source's level out of the flattened field outputs
  function automatic logic [LVL_W-1:0] ipr_level_of(
    input logic [NUM_SRC*LVL_W-1:0] lvls,
    input int src
  );
    ipr_level_of = lvls[src*LVL_W +: LVL_W];
  endfunction : ipr_level_of

  // True when a write to this word reaches a source's field through its byte lane
  function automatic logic ipr_field_hit(
    input logic [3:0] dec,
    input logic [1:0] strb,
    input int src
  );
    ipr_field_hit = ipr_writable(dec) && (dec[2:0] == FIELD_REG[src]) &&
                    strb[(FIELD_LSB[src] >= HIGH_LANE_LSB) ? 1 : 0];
  endfunction : ipr_field_hit

  // Builds a register image; bits outside a field stay zero, and the status word gets one enable bit per source
  function automatic logic [REG_W-1:0] ipr_read_word(
    input logic [2:0] idx,
    input logic [NUM_SRC*LVL_W-1:0] lvls
  );
    logic [REG_W-1:0] word;
    word = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (idx == IDX_ENABLE_STATUS)
      begin
        word[i] = (ipr_level_of(lvls, i) != LVL_OFF);
      end
      else if (FIELD_REG[i] == idx)
      begin
        word[FIELD_LSB[i] +: LVL_W] = ipr_level_of(lvls, i);
      end
    end
    ipr_read_word = word;
  endfunction : ipr_read_word

  ////////////////////////////////////////////////////////////////////////////
  // Priority fields

  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_field
      // Only the named field bits are stored; the rest has no storage
      assign field_wr[g] = wr_fire &&
                           ipr_field_hit(wr_dec, wr_strb_now, g);

      ipr_field u_field (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(field_wr[g]),
        .wr_level(wr_data_now[FIELD_LSB[g] +: LVL_W]),
        .level(lvl_flat[g*LVL_W +: LVL_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data accepted in either order

  always_comb
  begin
    // A channel counts as taken in the cycle its valid meets its ready
    aw_take = s_awvalid && st_r.awready;
    w_take = s_wvalid && st_r.wready;
    // The word taken now wins over the copy held from an earlier cycle
    wr_addr_now = aw_take ? s_awaddr : st_r.awaddr;
    wr_data_now = w_take ? s_wdata[REG_W-1:0] : st_r.wdata;
    wr_strb_now = w_take ? s_wstrb[1:0] : st_r.wstrb;
    wr_dec = ipr_decode(wr_addr_now);
    wr_fire = (st_r.aw_held || aw_take) &&
              (st_r.w_held || w_take) &&
              !st_r.bvalid;
    // Status word and unmapped space store nothing and answer an error
    wr_resp = ipr_writable(wr_dec) ? RESP_OKAY : RESP_SLVERR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: the image is built from the live field outputs

  always_comb
  begin
    ar_take = s_arvalid && st_r.arready;
    rd_dec = ipr_decode(s_araddr);
    rd_word = '0;
    rd_resp = RESP_SLVERR;
    if (rd_dec[3])
    begin
      rd_word = ipr_read_word(rd_dec[2:0], lvl_flat);
      rd_resp = RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source enables: level zero shuts a source off whatever it reports

  generate
    for (genvar s = 0; s < NUM_SRC; s++)
    begin : g_enable
      assign src_enabled[s] = (ipr_level_of(lvl_flat, s) != LVL_OFF);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt = st_r;

    // Write channels
    if (aw_take)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_awaddr;
    end
    if (w_take)
    begin
      // Upper half and lanes 3..2 land on bits that read as zero anyway
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_wdata[REG_W-1:0];
      st_nxt.wstrb = s_wstrb[1:0];
    end
    if (st_r.bvalid && s_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_resp;
    end
    // A new write waits until the previous response has gone
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    // Read channels
    if (st_r.rvalid && s_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      // Data and response are latched together and stand until rready
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = rd_resp;
      st_nxt.rdata = {{(DATA_W-REG_W){1'b0}},
                      rd_word};
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Level zero blocks the request whatever the source says
    for (int i = 0; i < NUM_SRC; i++)
    begin
      st_nxt.request[i] = src_pending[i] && src_enabled[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_awready = st_r.awready;
  assign s_wready = st_r.wready;
  assign s_bvalid = st_r.bvalid;
  assign s_bresp = st_r.bresp;
  assign s_arready = st_r.arready;
  assign s_rvalid = st_r.rvalid;
  assign s_rdata = st_r.rdata;
  assign s_rresp = st_r.rresp;
  assign source_request = st_r.request;

  // Code equals level, 3'h7 highest and 3'h1 lowest, straight from storage
  assign calendar_irq_level = lvl_flat[0*LVL_W +: LVL_W];
  assign checksum_err_irq_level = lvl_flat[1*LVL_W +: LVL_W];
  assign serial2_err_irq_level = lvl_flat[2*LVL_W +: LVL_W];
  assign serial1_err_irq_level = lvl_flat[3*LVL_W +: LVL_W];
  assign low_voltage_irq_level = lvl_flat[4*LVL_W +: LVL_W];
  assign charge_time_irq_level = lvl_flat[5*LVL_W +: LVL_W];
  assign serial3_tx_irq_level = lvl_flat[6*LVL_W +: LVL_W];
  assign serial3_rx_irq_level = lvl_flat[7*LVL_W +: LVL_W];
  assign serial3_err_irq_level = lvl_flat[8*LVL_W +: LVL_W];
  assign serial4_err_irq_level = lvl_flat[9*LVL_W +: LVL_W];
  assign twowire3_master_irq_level = lvl_flat[10*LVL_W +: LVL_W];
  assign twowire3_slave_irq_level = lvl_flat[11*LVL_W +: LVL_W];
  assign sync3_event_irq_level = lvl_flat[12*LVL_W +: LVL_W];
  assign sync3_fault_irq_level = lvl_flat[13*LVL_W +: LVL_W];
  assign serial4_tx_irq_level = lvl_flat[14*LVL_W +: LVL_W];
  assign serial4_rx_irq_level = lvl_flat[15*LVL_W +: LVL_W];

endmodule : ipr_regs
`default_nettype wire

// ---- ipr_regs_props.sv ----
/*
  Checker for the upper priority register bank, bound to ipr_regs.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ipr_regs_props
  import ipr_pkg::*;
(
  // Clock, reset and bus handshakes
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awready,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [ipr_pkg::DATA_W-1:0] s_rdata,
  // Sources and levels
  input wire logic [ipr_pkg::NUM_SRC-1:0] src_pending,
  input wire logic [ipr_pkg::NUM_SRC-1:0] source_request,
  input wire logic [2:0] calendar_irq_level,
  input wire logic [2:0] checksum_err_irq_level,
  input wire logic [2:0] serial2_err_irq_level,
  input wire logic [2:0] serial1_err_irq_level,
  input wire logic [2:0] low_voltage_irq_level,
  input wire logic [2:0] charge_time_irq_level,
  input wire logic [2:0] serial3_tx_irq_level,
  input wire logic [2:0] serial3_rx_irq_level,
  input wire logic [2:0] serial3_err_irq_level,
  input wire logic [2:0] serial4_err_irq_level,
  input wire logic [2:0] twowire3_master_irq_level,
  input wire logic [2:0] twowire3_slave_irq_level,
  input wire logic [2:0] sync3_event_irq_level,
  input wire logic [2:0] sync3_fault_irq_level,
  input wire logic [2:0] serial4_tx_irq_level,
  input wire logic [2:0] serial4_rx_irq_level
);
  logic [47:0] lv;
  logic [15:0] live;
  assign lv = {serial4_rx_irq_level, serial4_tx_irq_level, sync3_fault_irq_level, sync3_event_irq_level,
    twowire3_slave_irq_level, twowire3_master_irq_level, serial4_err_irq_level, serial3_err_irq_level,
    serial3_rx_irq_level, serial3_tx_irq_level, charge_time_irq_level, low_voltage_irq_level,
    serial1_err_irq_level, serial2_err_irq_level, checksum_err_irq_level, calendar_irq_level};
  always_comb
    for (int i = 0; i < 16; i++)
      live[i] = src_pending[i] && (lv[i*3+:3] != 3'h0);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BRESP_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  AST_RDATA_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  AST_UPPER_ZERO: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_GATE: assert property (1'b1 |=> source_request == $past(live))
    else $error("request not pending gated by level");
  AST_RESET_LEVEL: assert property ($rose(aresetn) |-> lv == {16{LVL_RESET}})
    else $error("levels not four after reset");
  AST_LEVEL_BY_WRITE: assert property ($past(aresetn) && !$rose(s_bvalid) |-> $stable(lv))
    else $error("level moved without a write");
  AST_WR_BUSY: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write ready while response pending");
  AST_RD_BUSY: assert property (s_rvalid |-> !s_arready)
    else $error("read ready while data pending");
  AST_WR_BACK: assert property (s_bvalid && s_bready |=> !s_bvalid && s_awready && s_wready)
    else $error("write channel not reopened");
endmodule : ipr_regs_props
`default_nettype wire

// ---- ipr_src_model.sv ----
/*
  Peripheral source model: pending flags as status flops would raise them.
  Assumes the bench says which flags to raise.
*/
`timescale 1ns/1ps
`default_nettype none
module ipr_src_model
  import ipr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flags to raise
  input wire logic [ipr_pkg::NUM_SRC-1:0] raise,
  // Pending flags to the bank
  output logic [ipr_pkg::NUM_SRC-1:0] src_pending
);
  // Flags only move on the clock, so the bank never sees a glitch
  always_ff @(posedge aclk)
    src_pending <= aresetn ? raise : '0;
endmodule : ipr_src_model
`default_nettype wire

// ---- test_interrupt_priority_regs_upper.sv ----
/*
  Self-checking bench for ipr_regs: AXI4-Lite master, source model, random and corner traffic.
  Assumes the package, design, checker and source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_regs_upper;
  import ipr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [5:0] s_awaddr = 6'h00, s_araddr = 6'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic [15:0] raise = 16'h0000;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [15:0] src_pending, source_request;
  logic [2:0] lv [16];
  logic [15:0] shadow [7];
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [15:0] FMASK [7] = '{16'h0700, 16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7077, 16'h7777};
  localparam int SRC_REG [16] = '{0, 1, 1, 1, 2, 3, 4, 4, 4, 5, 5, 5, 6, 6, 6, 6};
  localparam int SRC_LSB [16] = '{8, 12, 8, 4, 0, 4, 12, 8, 4, 12, 4, 0, 12, 8, 4, 0};
  always #10 aclk = ~aclk;
  ipr_regs #(.ADDR_W(6)) i_ipr_regs (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata, .s_wstrb,
    .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
    .s_rresp, .src_pending, .source_request, .calendar_irq_level(lv[0]), .checksum_err_irq_level(lv[1]),
    .serial2_err_irq_level(lv[2]), .serial1_err_irq_level(lv[3]), .low_voltage_irq_level(lv[4]),
    .charge_time_irq_level(lv[5]), .serial3_tx_irq_level(lv[6]), .serial3_rx_irq_level(lv[7]),
    .serial3_err_irq_level(lv[8]), .serial4_err_irq_level(lv[9]), .twowire3_master_irq_level(lv[10]),
    .twowire3_slave_irq_level(lv[11]), .sync3_event_irq_level(lv[12]), .sync3_fault_irq_level(lv[13]),
    .serial4_tx_irq_level(lv[14]), .serial4_rx_irq_level(lv[15]));
  ipr_src_model i_ipr_src_model (.aclk, .aresetn, .raise, .src_pending);
  ////////////////////////////////////////
  function automatic logic [2:0] exp_lvl(input int i);
    return shadow[SRC_REG[i]][SRC_LSB[i]+:3];
  endfunction : exp_lvl
  function automatic logic [15:0] exp_req(input logic [15:0] p);
    logic [15:0] r;
    for (int i = 0; i < 16; i++)
      r[i] = p[i] && (exp_lvl(i) != 3'h0);
    return r;
  endfunction : exp_req
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang;
    n_fail++;
    $display("[ERR] handshake expected answer seen none");
    final_report();
  endtask : hang
  ////////////////////////////////////////
  // Bready and rready go up with the request; the slave must answer within 40 cycles
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      n++;
    end while (s_bvalid !== 1'b1 && n < 40);
    if (s_bvalid !== 1'b1)
      hang();
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready)
        s_arvalid <= 1'b0;
      n++;
    end while (s_rvalid !== 1'b1 && n < 40);
    if (s_rvalid !== 1'b1)
      hang();
    d = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_read
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] st);
    logic [1:0] rs;
    int k;
    k = int'(a[5:2]);
    axi_write(a, d, st, rs);
    if (k < 7)
    begin
      if (st[0])
        shadow[k][7:0] = d[7:0];
      if (st[1])
        shadow[k][15:8] = d[15:8];
      shadow[k] &= FMASK[k];
    end
    chk("bresp", 32'(rs), (k < 7) ? 32'(RESP_OKAY) : 32'(RESP_SLVERR));
  endtask : wr
  task automatic check_all;
    logic [31:0] rd;
    logic [1:0] rs;
    for (int k = 0; k < 7; k++)
    begin
      axi_read(6'(k * 4), rd, rs);
      chk("rdata", rd, {16'h0000, shadow[k]});
      chk("rresp", 32'(rs), 32'(RESP_OKAY));
    end
    for (int i = 0; i < 16; i++)
      chk("level", 32'(lv[i]), 32'(exp_lvl(i)));
    chk("request", 32'(source_request), 32'(exp_req(raise)));
  endtask : check_all
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 7; k++)
      shadow[k] = FMASK[k] & 16'h4444;
    check_all();
  endtask : do_reset
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] rd;
    logic [1:0] rs;
    void'($urandom(32'h644B28B9));
    do_reset();
    // Every code in every field, with the same code thrown at the unused nibbles too
    for (int c = 0; c < 8; c++)
    begin
      raise <= 16'($urandom());
      for (int k = 0; k < 7; k++)
        wr(6'(k * 4), 32'(c) * 32'h11111111, 4'hF);
      check_all();
    end
    for (int t = 0; t < 40; t++)
    begin
      raise <= 16'($urandom());
      wr(6'($urandom_range(6, 0) * 4 + $urandom_range(3, 0)), $urandom(), 4'($urandom()));
      check_all();
    end
    wr(6'h1C, 32'hFFFFFFFF, 4'hF);
    wr(6'h20, 32'hFFFFFFFF, 4'hF);
    axi_read(6'h1C, rd, rs);
    chk("status", rd, {16'h0000, exp_req(16'hFFFF)});
    chk("status rresp", 32'(rs), 32'(RESP_OKAY));
    axi_read(6'h24, rd, rs);
    chk("unmapped rdata", rd, 32'h0);
    chk("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
    check_all();
    do_reset();
    final_report();
  end
endmodule : test_interrupt_priority_regs_upper
bind ipr_regs ipr_regs_props i_ipr_regs_props (.aclk, .aresetn, .s_awready, .s_wready, .s_bvalid, .s_bready,
  .s_bresp, .s_arready, .s_rvalid, .s_rready, .s_rdata, .src_pending, .source_request, .calendar_irq_level,
  .checksum_err_irq_level, .serial2_err_irq_level, .serial1_err_irq_level, .low_voltage_irq_level,
  .charge_time_irq_level, .serial3_tx_irq_level, .serial3_rx_irq_level, .serial3_err_irq_level,
  .serial4_err_irq_level, .twowire3_master_irq_level, .twowire3_slave_irq_level, .sync3_event_irq_level,
  .sync3_fault_irq_level, .serial4_tx_irq_level, .serial4_rx_irq_level);
`default_nettype wire
